// ---- verilog/eeprom_consts.svh ----
// Shared constants for the two-wire serial EEPROM slave core
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// Array geometry
`define MEM_BYTES 16384
`define ADDR_BITS 14
`define PAGE_BITS 6

// Fixed upper nibble of the slave address byte
`define SLAVE_ID 4'hA

// Bit slot of the acknowledge within a nine-bit byte frame
`define ACK_SLOT 4'h8

// Depth of the bit ring between the link and the core, as index bits
`define RING_BITS 3

// Programming time and the cycle count derived from the core rate
`define PROG_TIME_MS 5
`define CORE_CLK_KHZ 40000
`define PROG_CYCLES (`PROG_TIME_MS * `CORE_CLK_KHZ)

// Reset values
`define STANDBY_RESET 1'b1

`endif

// ---- verilog/eeprom_pkg.sv ----
// Types shared by the serial EEPROM slave core
package eeprom_pkg;

    // Byte-level phase of a bus transaction
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_DEV    = 3'b001,
        PH_AHI    = 3'b010,
        PH_ALO    = 3'b011,
        PH_WDAT   = 3'b100,
        PH_RDAT   = 3'b101,
        PH_IGNORE = 3'b110
    } phase_t;

endpackage

// ---- verilog/bit_sync.sv ----
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1; // Metastable stage, read only by sync_o

    // Plain data path: no reset, settles within two edges
    always_ff @(posedge clk_i) begin
        stage1 <= async_i;
        sync_o <= stage1;
    end

endmodule

// ---- verilog/prog_timer.sv ----
// Self-timed programming cycle counter
`timescale 1ns/1ps
module prog_timer #(
    parameter int CYCLES = 200000
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic busy_o
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count; // Cycles left in the current cycle

    // Busy for exactly CYCLES core edges after a start
    always_ff @(posedge clk_i) begin
        if (reset_i || abort_i) begin
            count <= '0;
            busy_o <= 1'b0;
        end else if (start_i && !busy_o) begin
            count <= CW'(CYCLES - 1);
            busy_o <= 1'b1;
        end else if (busy_o) begin
            // Ends on its own, no master clock needed
            if (count == '0) begin
                busy_o <= 1'b0;
            end else begin
                count <= count - CW'(1);
            end
        end
    end

endmodule

// ---- verilog/serial_eeprom_slave_core.sv ----
// Two-wire serial EEPROM slave core with page programming
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module serial_eeprom_slave_core
    import eeprom_pkg::*;
#(
    parameter int MEM_DEPTH = `MEM_BYTES,
    parameter int ADDR_W = `ADDR_BITS,
    parameter int PAGE_W = `PAGE_BITS,
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic chip_addr_strap_bit0_i,
    input wire logic chip_addr_strap_bit1_i,
    input wire logic chip_addr_strap_bit2_i,
    input wire logic write_protect_i,
    input wire logic supply_ok_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic standby_o,
    output logic prog_busy_o
);

    localparam int RING_AW = `RING_BITS;
    localparam int RING_N = 1 << RING_AW;
    localparam int PAGE_BYTES = 1 << PAGE_W;
    localparam int PAGE_NUM_W = ADDR_W - PAGE_W;

    // ------------------------------------------------------------
    // Link domain: one bit captured per rising serial clock edge
    // ------------------------------------------------------------

    logic link_reset; // Core reset carried onto the serial clock
    logic [RING_N-1:0] bit_ring; // Captured data bits, written on scl
    logic [RING_AW-1:0] wr_ptr; // Binary write index
    logic [RING_AW-1:0] next_wr_ptr; // Index after this capture
    logic [RING_AW-1:0] wr_gray; // Gray copy that crosses to the core

    // Serial clock only runs in frames, so hold reset over some edges
    bit_sync #(
        .WIDTH(1)
    ) u_link_rst (
        .clk_i(scl_i),
        .async_i(reset_i),
        .sync_o(link_reset)
    );

    assign next_wr_ptr = wr_ptr + RING_AW'(1);

    // Data is valid while the clock is high, so sample on its rise
    always_ff @(posedge scl_i) begin
        bit_ring[wr_ptr] <= sda_i;
    end

    // Write pointer, gray coded so a crossing sees one bit change
    always_ff @(posedge scl_i) begin
        if (link_reset) begin
            wr_ptr <= '0;
            wr_gray <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            wr_gray <= next_wr_ptr ^ (next_wr_ptr >> 1);
        end
    end

    // ------------------------------------------------------------
    // Core domain: synchronised pins and pointer
    // ------------------------------------------------------------

    logic scl_s; // Serial clock level, synchronised
    logic sda_s; // Data line level, synchronised
    logic wp_s; // Write protect, high means read-only
    logic [2:0] strap_s; // Chip address straps
    logic supply_s; // Supply above the reset threshold
    logic [RING_AW-1:0] wr_gray_s; // Write pointer in the core domain
    logic [RING_AW-1:0] wr_bin_s; // Same pointer back in binary

    bit_sync #(
        .WIDTH(7)
    ) u_pin_sync (
        .clk_i(core_clk_i),
        .async_i({scl_i, sda_i, write_protect_i, chip_addr_strap_bit2_i,
                  chip_addr_strap_bit1_i, chip_addr_strap_bit0_i,
                  supply_ok_i}),
        .sync_o({scl_s, sda_s, wp_s, strap_s, supply_s})
    );

    bit_sync #(
        .WIDTH(RING_AW)
    ) u_ptr_sync (
        .clk_i(core_clk_i),
        .async_i(wr_gray),
        .sync_o(wr_gray_s)
    );

    // Gray to binary by running parity from the top bit down
    always_comb begin
        wr_bin_s[RING_AW-1] = wr_gray_s[RING_AW-1];
        for (int i = RING_AW - 2; i >= 0; i--) begin
            wr_bin_s[i] = wr_bin_s[i+1] ^ wr_gray_s[i];
        end
    end

    // ------------------------------------------------------------
    // Bus events and decode
    // ------------------------------------------------------------

    logic scl_p; // Previous serial clock level
    logic sda_p; // Previous data line level
    logic por_hold; // Supply too low, bus is ignored
    logic start_ev; // Data fell while clock high
    logic stop_ev; // Data rose while clock high
    logic scl_fall; // Clock went low, data may change now
    logic [RING_AW-1:0] rd_ptr; // Next ring bit to consume
    logic bit_avail; // Ring holds an unread bit
    logic cur_bit; // The oldest unread bit
    logic take_bit; // Bit is acted on this cycle
    logic last_bit; // Eighth data bit of a byte
    logic ack_slot; // Ninth bit, the acknowledge slot
    logic [7:0] full_byte; // Byte completed by the current bit
    logic dev_match; // Address byte selects this device
    logic wr_allowed; // Array writes permitted

    phase_t phase; // Transaction phase
    logic [3:0] bit_cnt; // Bit within the nine-bit frame
    logic [7:0] shift_in; // Received bits so far
    logic ack; // We acknowledge the current byte
    logic rw; // Direction bit of the last address
    logic [ADDR_W-1:0] addr; // Word address: page and byte fields
    logic [7:0] tx_byte; // Byte being sent to the master
    logic prog_start; // Stop closing a write with data
    logic prog_busy; // Programming cycle in progress
    logic next_oe; // Drive value for the coming low phase

    // Edge history for start and stop detection
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    assign por_hold = !supply_s;
    assign start_ev = scl_s && scl_p && sda_p && !sda_s;
    assign stop_ev = scl_s && scl_p && !sda_p && sda_s;
    assign scl_fall = scl_p && !scl_s;
    assign bit_avail = rd_ptr != wr_bin_s;
    assign cur_bit = bit_ring[rd_ptr];
    assign take_bit = bit_avail && !start_ev && !stop_ev && !por_hold;
    assign last_bit = take_bit && (bit_cnt == 4'h7);
    assign ack_slot = take_bit && (bit_cnt == `ACK_SLOT);
    assign full_byte = {shift_in[6:0], cur_bit};
    // Straps need board pull-downs so a floating pin arrives as zero
    assign dev_match = (full_byte[7:4] == `SLAVE_ID)
        && (full_byte[3:1] == strap_s)
        && !prog_busy;
    assign wr_allowed = !wp_s;

    // Read pointer; a start discards any stale bits in the ring
    always_ff @(posedge core_clk_i) begin
        if (reset_i || start_ev) begin
            rd_ptr <= wr_bin_s;
        end else if (bit_avail) begin
            rd_ptr <= rd_ptr + RING_AW'(1);
        end
    end

    // ------------------------------------------------------------
    // Transaction phase machine
    // ------------------------------------------------------------

    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_hold) begin
            // Supply loss or reset lands in standby
            phase <= PH_IDLE;
            bit_cnt <= '0;
            shift_in <= '0;
            ack <= 1'b0;
            rw <= 1'b0;
        end else if (start_ev) begin
            // Also a repeated start, which abandons the frame
            phase <= PH_DEV;
            bit_cnt <= '0;
            ack <= 1'b0;
        end else if (stop_ev) begin
            phase <= PH_IDLE;
            bit_cnt <= '0;
            ack <= 1'b0;
        end else if (take_bit) begin
            if (bit_cnt == `ACK_SLOT) begin
                bit_cnt <= '0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift_in <= full_byte;
            end
            // Decide the acknowledge once the byte is whole
            if (last_bit) begin
                unique case (phase)
                    PH_DEV: begin
                        ack <= dev_match;
                        rw <= full_byte[0];
                    end
                    PH_AHI, PH_ALO: ack <= 1'b1;
                    PH_WDAT: ack <= wr_allowed;
                    PH_IDLE, PH_RDAT, PH_IGNORE: ack <= 1'b0;
                    default: ack <= 1'b0;
                endcase
            end
            // Move on after the acknowledge slot
            if (ack_slot) begin
                unique case (phase)
                    PH_DEV: begin
                        if (!ack) begin
                            phase <= PH_IGNORE;
                        end else if (rw) begin
                            phase <= PH_RDAT;
                        end else begin
                            phase <= PH_AHI;
                        end
                    end
                    PH_AHI: phase <= PH_ALO;
                    PH_ALO: phase <= PH_WDAT;
                    PH_WDAT: phase <= ack ? PH_WDAT : PH_IGNORE;
                    // Master high in its slot ends the read
                    PH_RDAT: phase <= cur_bit ? PH_IGNORE : PH_RDAT;
                    PH_IDLE, PH_IGNORE: phase <= phase;
                    default: phase <= PH_IGNORE;
                endcase
            end
        end
    end

    // Word address counter
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            addr <= '0;
        end else if (last_bit && (phase == PH_AHI)) begin
            // Top bits of the high byte are don't care
            addr[ADDR_W-1:8] <= full_byte[ADDR_W-9:0];
        end else if (last_bit && (phase == PH_ALO)) begin
            addr[7:0] <= full_byte;
        end else if (last_bit && (phase == PH_WDAT) && wr_allowed) begin
            // Wraps inside the page, page field untouched
            addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + PAGE_W'(1);
        end else if (ack_slot && (((phase == PH_DEV) && ack && rw)
                                  || ((phase == PH_RDAT) && !cur_bit))) begin
            // Reads walk the whole array and wrap at the end
            addr <= addr + ADDR_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Array, page buffer and programming
    // ------------------------------------------------------------

    logic [7:0] mem [MEM_DEPTH]; // Non-volatile array, one byte each
    logic [7:0] page_buf [PAGE_BYTES]; // Bytes collected for one page
    logic [PAGE_BYTES-1:0] wr_mask; // Which page bytes were received
    logic committing; // Copying the page buffer into the array
    logic [PAGE_W-1:0] commit_idx; // Byte being copied
    logic [PAGE_NUM_W-1:0] commit_page; // Page fixed at the stop

    // Outgoing byte, fetched as the read frame opens
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tx_byte <= '0;
        end else if (ack_slot && (((phase == PH_DEV) && ack && rw)
                                  || ((phase == PH_RDAT) && !cur_bit))) begin
            tx_byte <= mem[addr];
        end
    end

    // Incoming data collects here; rollover overwrites earlier bytes
    always_ff @(posedge core_clk_i) begin
        if (last_bit && (phase == PH_WDAT) && wr_allowed) begin
            page_buf[addr[PAGE_W-1:0]] <= full_byte;
        end
    end

    // Received-byte mask, cleared as each new write opens
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_hold) begin
            wr_mask <= '0;
        end else if (ack_slot && (phase == PH_ALO)) begin
            wr_mask <= '0;
        end else if (last_bit && (phase == PH_WDAT) && wr_allowed) begin
            wr_mask[addr[PAGE_W-1:0]] <= 1'b1;
        end
    end

    // A stop after written data starts the cycle; protect blocks it
    assign prog_start = stop_ev && (phase == PH_WDAT) && (|wr_mask)
        && wr_allowed && !por_hold && !prog_busy;

    prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_prog_timer (
        .clk_i(core_clk_i),
        .reset_i(reset_i),
        .start_i(prog_start),
        .abort_i(por_hold),
        .busy_o(prog_busy)
    );

    // Page copy runs at the start of the timed cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_hold) begin
            committing <= 1'b0;
            commit_idx <= '0;
            commit_page <= '0;
        end else if (prog_start) begin
            committing <= 1'b1;
            commit_idx <= '0;
            commit_page <= addr[ADDR_W-1:PAGE_W];
        end else if (committing) begin
            commit_idx <= commit_idx + PAGE_W'(1);
            if (commit_idx == PAGE_W'(PAGE_BYTES - 1)) begin
                committing <= 1'b0;
            end
        end
    end

    // Only received bytes are written, the rest keep their data
    always_ff @(posedge core_clk_i) begin
        if (committing && wr_mask[commit_idx]) begin
            mem[{commit_page, commit_idx}] <= page_buf[commit_idx];
        end
    end

    // ------------------------------------------------------------
    // Data line drive and status outputs
    // ------------------------------------------------------------

    // What to put on the line once the clock has gone low
    always_comb begin
        next_oe = 1'b0;
        unique case (phase)
            PH_DEV, PH_AHI, PH_ALO, PH_WDAT: begin
                next_oe = (bit_cnt == `ACK_SLOT) && ack;
            end
            PH_RDAT: begin
                // Master owns the slot after each byte
                next_oe = (bit_cnt != `ACK_SLOT)
                    && !tx_byte[3'h7 - bit_cnt[2:0]];
            end
            PH_IDLE, PH_IGNORE: next_oe = 1'b0;
            default: next_oe = 1'b0;
        endcase
    end

    // Change the line only while the clock is low
    always_ff @(posedge core_clk_i) begin
        if (reset_i || por_hold || start_ev || stop_ev) begin
            sda_oe_o <= 1'b0;
        end else if (scl_fall) begin
            sda_oe_o <= next_oe;
        end
    end

    // Open drain: the pad only ever pulls low
    always_ff @(posedge core_clk_i) begin
        sda_o <= 1'b0;
    end

    // Standby status
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            standby_o <= `STANDBY_RESET;
            prog_busy_o <= 1'b0;
        end else begin
            standby_o <= por_hold || ((phase == PH_IDLE) && !prog_busy);
            prog_busy_o <= prog_busy;
        end
    end

endmodule

// ---- sim/serial_eeprom_slave_core_sva.sv ----
// Port checks for the serial EEPROM slave core
`timescale 1ns/1ps
module serial_eeprom_slave_core_sva #(
    parameter int PROG_CYCLES = 200000
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic write_protect_i,
    input wire logic supply_ok_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic standby_o,
    input wire logic prog_busy_o
);
    int busy_cnt; // Cycles into the running program
    // Counts busy cycles, zero when idle
    always_ff @(posedge core_clk_i) begin
        busy_cnt <= (reset_i || !prog_busy_o) ? 0 : busy_cnt + 1;
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // Busy seen on two edges in a row
    sequence s_busy_run; prog_busy_o ##1 prog_busy_o; endsequence
    // Standby back within two edges
    sequence s_standby_soon; ##[0:2] standby_o; endsequence
    property p_sda_zero; sda_o == 1'b0; endproperty
    a_sda_zero: assert property (p_sda_zero)
        else $error("data output value not zero");
    property p_prog_len; prog_busy_o |-> busy_cnt < PROG_CYCLES; endproperty
    a_prog_len: assert property (p_prog_len)
        else $error("programming ran too long");
    property p_busy_quiet; s_busy_run |-> !sda_oe_o; endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("line driven while programming");
    property p_busy_standby; $rose(prog_busy_o) |=> !standby_o; endproperty
    a_busy_standby: assert property (p_busy_standby)
        else $error("standby while programming");
    property p_prog_end;
        $fell(prog_busy_o) && supply_ok_i |-> s_standby_soon;
    endproperty
    a_prog_end: assert property (p_prog_end)
        else $error("no standby after programming");
    property p_supply_low;
        !supply_ok_i [*8] |-> standby_o && !sda_oe_o && !prog_busy_o;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("active while supply low");
    property p_wp_block; write_protect_i [*8] |-> !$rose(prog_busy_o); endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("programming under write protect");
    property p_oe_rise; $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2); endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("line pulled outside clock low");
    property p_oe_hold;
        scl_i && $past(scl_i) && supply_ok_i |-> $stable(sda_oe_o);
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("line changed while clock high");
endmodule

bind serial_eeprom_slave_core serial_eeprom_slave_core_sva #(
    .PROG_CYCLES(PROG_CYCLES)
) u_sva (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .scl_i(scl_i),
    .write_protect_i(write_protect_i), .supply_ok_i(supply_ok_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_o(standby_o),
    .prog_busy_o(prog_busy_o)
);

// ---- sim/bus_master_model.sv ----
// Two-wire bus master model for the serial EEPROM core
`timescale 1ns/1ps
module bus_master_model (
    input wire logic tick_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Idle: clock high and still, line released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Third of a bit of four ticks, above the 150 ns phase minimum
    task automatic wait_q();
        repeat (4) @(posedge tick_i);
    endtask
    // One pulse; a one is sent by releasing, read back at clock high
    task automatic bit_io(input logic b, output logic r);
        sda_low_o <= !b;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        r = sda_i;
        scl_o <= 1'b0;
        wait_q();
    endtask
    // Start or repeated start: line falls with clock high
    task automatic start();
        sda_low_o <= 1'b0;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        sda_low_o <= 1'b1;
        wait_q();
        scl_o <= 1'b0;
        wait_q();
    endtask
    // Stop: line rises with clock high, then clock stands
    task automatic stop();
        sda_low_o <= 1'b1;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        sda_low_o <= 1'b0;
        wait_q();
    endtask
    // Byte out, MSB first; ack true when the slave pulled low
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Byte in, MSB first, then our acknowledge or refusal
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// ---- sim/serial_eeprom_slave_core_tb.sv ----
// Self-checking testbench for the serial EEPROM slave core
`timescale 1ns/1ps
module serial_eeprom_slave_core_tb;
    localparam int PROG = 600; // Short programming time
    localparam int LIMIT = 60000; // Cycle ceiling for the run
    logic core_clk = 1'b0;
    logic tick = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strap = 3'h0;
    logic wp = 1'b0;
    logic supply = 1'b1;
    logic scl, m_low, sda_o, sda_oe, standby, busy;
    wire sda;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    // Pull-up: low if either side pulls
    assign sda = !(sda_oe || m_low);
    serial_eeprom_slave_core #(.PROG_CYCLES(PROG)) dut (
        .core_clk_i(core_clk), .reset_i(reset), .scl_i(scl), .sda_i(sda),
        .chip_addr_strap_bit0_i(strap[0]), .chip_addr_strap_bit1_i(strap[1]),
        .chip_addr_strap_bit2_i(strap[2]), .write_protect_i(wp),
        .supply_ok_i(supply), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .standby_o(standby), .prog_busy_o(busy)
    );
    bus_master_model m (
        .tick_i(tick), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low)
    );
    initial begin
        forever #12.5 core_clk = !core_clk;
    end
    // Link timebase, offset so the two never line up
    initial begin
        #5;
        forever #24 tick = !tick;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_byte(string w, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_bit(string w, logic e, logic g);
        cmp_byte(w, {7'h0, e}, {7'h0, g});
    endtask
    // Sample after the edge's updates have landed
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask
    // Start plus an address byte, judging the acknowledge
    task automatic dev(logic [7:0] b, logic e, string w);
        logic ack;
        m.start();
        m.send_byte(b, ack);
        cmp_bit(w, e, ack);
    endtask
    task automatic wait_prog();
        int n;
        n = 0;
        while (busy === 1'b1 && n < PROG) begin
            settle();
            n++;
        end
        cmp_bit("busy over", 1'b0, busy);
        settle();
        cmp_bit("standby after write", 1'b1, standby);
    endtask
    task automatic write_bytes(logic [13:0] a, logic [7:0] q[$], logic ok);
        logic ack;
        dev({4'hA, strap, 1'b0}, 1'b1, "write addr ack");
        m.send_byte({2'b00, a[13:8]}, ack);
        m.send_byte(a[7:0], ack);
        foreach (q[i]) begin
            m.send_byte(q[i], ack);
            cmp_bit("data ack", ok, ack);
        end
        m.stop();
        settle();
        cmp_bit("busy after stop", ok, busy);
        cmp_bit("standby after stop", !ok, standby);
        if (ok) begin
            dev({4'hA, strap, 1'b0}, 1'b0, "poll nack");
            m.stop();
            wait_prog();
        end
    endtask
    task automatic read_bytes(logic [13:0] a, logic [7:0] q[$]);
        logic ack;
        logic [7:0] d;
        dev({4'hA, strap, 1'b0}, 1'b1, "dummy ack");
        m.send_byte({2'b00, a[13:8]}, ack);
        m.send_byte(a[7:0], ack);
        dev({4'hA, strap, 1'b1}, 1'b1, "read addr ack");
        foreach (q[i]) begin
            m.recv_byte(i == q.size() - 1, d);
            cmp_byte("read data", q[i], d);
        end
        m.stop();
    endtask
    // Every strap code, a neighbour code and a wrong fixed nibble
    task automatic t_straps();
        for (int s = 0; s < 8; s++) begin
            @(posedge core_clk) strap <= s[2:0];
            repeat (4) settle();
            dev({4'hA, s[2:0] ^ 3'h1, 1'b0}, 1'b0, "other strap");
            dev({4'hB, s[2:0], 1'b0}, 1'b0, "bad nibble");
            dev({4'hA, s[2:0], 1'b0}, 1'b1, "own strap");
            m.stop();
        end
    endtask
    // Last page: partial write that wraps inside the page
    task automatic t_page();
        write_bytes(14'h0000, {8'h11}, 1'b1);
        write_bytes(14'h3FC1, {8'h5A}, 1'b1);
        write_bytes(14'h3FFE, {8'hA1, 8'hB2, 8'hC3}, 1'b1);
        read_bytes(14'h3FFE, {8'hA1, 8'hB2, 8'h11});
        read_bytes(14'h3FC0, {8'hC3, 8'h5A});
    endtask
    task automatic t_protect();
        @(posedge core_clk) wp <= 1'b1;
        repeat (4) settle();
        write_bytes(14'h0000, {8'hEE}, 1'b0);
        read_bytes(14'h0000, {8'h11});
        @(posedge core_clk) wp <= 1'b0;
    endtask
    task automatic t_supply();
        @(posedge core_clk) supply <= 1'b0;
        repeat (10) settle();
        cmp_bit("standby low supply", 1'b1, standby);
        dev({4'hA, strap, 1'b1}, 1'b0, "low supply nack");
        m.stop();
        @(posedge core_clk) supply <= 1'b1;
        repeat (10) settle();
        cmp_bit("standby supply back", 1'b1, standby);
        read_bytes(14'h3FC1, {8'h5A});
    endtask
    // Reset spans three quiet clock rises; the first pulse has none
    // because the clock idles high. The link reset is carried on the
    // serial clock, so two more quiet pulses after release let it fall
    // before the first start, or the first address bit would be lost.
    initial begin
        logic r;
        repeat (4) m.bit_io(1'b1, r);
        @(posedge core_clk) reset <= 1'b0;
        repeat (4) settle();
        cmp_bit("standby at reset", 1'b1, standby);
        cmp_bit("busy at reset", 1'b0, busy);
        cmp_bit("drive at reset", 1'b0, sda_oe);
        cmp_bit("data value at reset", 1'b0, sda_o);
        repeat (2) m.bit_io(1'b1, r);
        t_straps();
        t_page();
        t_protect();
        t_supply();
        close_out();
    end
endmodule
